/* stx_serial_in.sv */
/*
 * serial audio input stage of the biphase transmitter: deserialises
 * left-justified, i2s or right-justified stereo words and divides the
 * oversampling clock down to the biphase rate.
 * assumes all pins are asynchronous to clock and that the bit clock and
 * oversampling clock run well below a quarter of the clock rate.
 * configuration inputs are not resynchronised; change them only while idle.
 */
`timescale 1ns/1ns
`default_nettype none

module stx_serial_in (
	// system
	input  wire logic        clock,
	input  wire logic        sys_rst,
	// configuration, same clock domain
	input  wire logic [1:0]  format_sel,
	input  wire logic [1:0]  width_sel,
	input  wire logic        ratio_384,
	// serial input pins
	input  wire logic        bit_clk_pin,
	input  wire logic        frame_sync_pin,
	input  wire logic        data_pin,
	input  wire logic        oversampling_clock_in,
	// sample output
	output var  logic [23:0] left_sample,
	output var  logic [23:0] right_sample,
	output var  logic        sample_valid,
	// biphase timing
	output var  logic        biphase_tick,
	output var  logic        biphase_clk
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [5:0] word_bits(input logic [1:0] w);
		case (stx_pkg::stx_width_t'(w))
			stx_pkg::STX_W16: word_bits = stx_pkg::STX_BITS_16;
			stx_pkg::STX_W18: word_bits = stx_pkg::STX_BITS_18;
			stx_pkg::STX_W20: word_bits = stx_pkg::STX_BITS_20;
			default:          word_bits = stx_pkg::STX_BITS_24;
		endcase
	endfunction

	function automatic logic [5:0] msb_delay(input logic [1:0] f, input logic [1:0] w);
		msb_delay = stx_pkg::STX_I2S_DLY;
		if (f == stx_pkg::STX_FMT_LJ) begin
			msb_delay = stx_pkg::STX_LJ_DLY;
		end else if (f == stx_pkg::STX_FMT_RJ) begin
			case (stx_pkg::stx_width_t'(w))
				stx_pkg::STX_W16: msb_delay = stx_pkg::STX_RJ_DLY_16;
				stx_pkg::STX_W18: msb_delay = stx_pkg::STX_RJ_DLY_18;
				stx_pkg::STX_W20: msb_delay = stx_pkg::STX_RJ_DLY_20;
				default:          msb_delay = stx_pkg::STX_RJ_DLY_24;
			endcase
		end
	endfunction

	function automatic logic [1:0] osr_divisor(input logic sel);
		logic [9:0] ratio;
		ratio       = sel ? stx_pkg::STX_OSR_384 : stx_pkg::STX_OSR_256;
		osr_divisor = 2'(ratio / stx_pkg::STX_BIPHASE_FRAME);
	endfunction

	function automatic logic [5:0] next_pos(input logic seen, input logic fs_edge,
		input logic [5:0] p);
		// until the first sync edge the count parks outside every word window
		if (!seen) begin
			next_pos = stx_pkg::STX_POS_MAX;
		end else if (fs_edge) begin
			next_pos = 6'h00;
		end else if (p == stx_pkg::STX_POS_MAX) begin
			next_pos = stx_pkg::STX_POS_MAX;
		end else begin
			next_pos = p + 6'h01;
		end
	endfunction

	function automatic logic left_channel(input logic [1:0] f, input logic fs);
		// i2s and unused code 3 take the i2s polarity
		if (f == stx_pkg::STX_FMT_LJ || f == stx_pkg::STX_FMT_RJ) begin
			left_channel = fs;
		end else begin
			left_channel = ~fs;
		end
	endfunction

	function automatic logic [23:0] align_left(input logic [23:0] w, input logic [5:0] bits);
		// excess early bits fall off the top
		align_left = w << (6'(stx_pkg::STX_SAMPLE_W) - bits);
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0]  bck_sync;
		logic        bck_d;
		logic [1:0]  fs_sync;
		logic [1:0]  dat_sync;
		logic [1:0]  osc_sync;
		logic        osc_d;
		logic [2:0]  warm;
		logic        seen;
		logic        fs_last;
		logic [5:0]  pos;
		logic [23:0] shift;
		logic [23:0] left_w;
		logic [23:0] right_w;
		logic        valid;
	} stx_state_t;

	stx_state_t st_reg;
	stx_state_t st_next;

	logic       armed;
	logic       bck_rise;
	logic       osc_rise;
	logic [1:0] divisor;

	// ----------------------------------------------------------------
	// edge detection
	// ----------------------------------------------------------------
	// edges stay masked until the sync chain refills after reset, so a pin
	// idling high gives no false rise; the first sync stage stays private
	assign armed    = st_reg.warm[2];
	assign bck_rise = armed & st_reg.bck_sync[1] & ~st_reg.bck_d;
	assign osc_rise = armed & st_reg.osc_sync[1] & ~st_reg.osc_d;
	assign divisor  = osr_divisor(ratio_384);

	// ----------------------------------------------------------------
	// deserialiser
	// ----------------------------------------------------------------
	always_comb begin
		logic [5:0]  pos;
		logic [5:0]  msb;
		logic [5:0]  bits;
		logic [5:0]  last;
		logic        fs;
		logic        is_left;
		logic [23:0] sh;
		pos     = 6'h00;
		msb     = msb_delay(format_sel, width_sel);
		bits    = word_bits(width_sel);
		last    = msb + bits - 6'h01;
		fs      = st_reg.fs_sync[1];
		is_left = 1'b0;
		sh      = st_reg.shift;

		st_next          = st_reg;
		st_next.bck_sync = {st_reg.bck_sync[0], bit_clk_pin};
		st_next.fs_sync  = {st_reg.fs_sync[0], frame_sync_pin};
		st_next.dat_sync = {st_reg.dat_sync[0], data_pin};
		st_next.osc_sync = {st_reg.osc_sync[0], oversampling_clock_in};
		st_next.bck_d    = st_reg.bck_sync[1];
		st_next.osc_d    = st_reg.osc_sync[1];
		st_next.warm     = {st_reg.warm[1:0], 1'b1};
		st_next.valid    = 1'b0;

		// fs and data share the bit clock's sync delay, so they line up
		if (bck_rise) begin
			pos             = next_pos(st_reg.seen, fs != st_reg.fs_last, st_reg.pos);
			st_next.seen    = 1'b1;
			st_next.fs_last = fs;
			st_next.pos     = pos;
			is_left         = left_channel(format_sel, fs);
			if (st_reg.seen && pos >= msb && pos <= last) begin
				sh            = {st_reg.shift[22:0], st_reg.dat_sync[1]};
				st_next.shift = sh;
				if (pos == last) begin
					// left word is stored silently; the right word closes the pair
					if (is_left) begin
						st_next.left_w = align_left(sh, bits);
					end else begin
						st_next.right_w = align_left(sh, bits);
						st_next.valid   = 1'b1;
					end
				end
			end
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------------------------------
	// biphase clock divider
	// ----------------------------------------------------------------
	// edges are seen through the synchroniser, so the oversampling clock
	// must stay below a quarter of clock; faster clocks lose edges
	stx_biphase_div u_div (
		.clock        (clock),
		.sys_rst      (sys_rst),
		.divisor      (divisor),
		.edge_tick    (osc_rise),
		.biphase_tick (biphase_tick),
		.biphase_clk  (biphase_clk)
	);

	// ----------------------------------------------------------------
	// sample outputs
	// ----------------------------------------------------------------
	assign left_sample  = st_reg.left_w;
	assign right_sample = st_reg.right_w;
	assign sample_valid = st_reg.valid;

endmodule

`default_nettype wire

/* stx_pkg.sv */
/*
 * shared constants and types for the transmitter serial input stage:
 * input formats, word widths, msb delays, oversampling ratios.
 * assumes every user writes stx_pkg::name; nothing is imported.
 */
`default_nettype none

package stx_pkg;

	// ----------------------------------------------------------------
	// input format and word width codes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		STX_FMT_I2S = 2'h0,
		STX_FMT_LJ  = 2'h1,
		STX_FMT_RJ  = 2'h2
	} stx_fmt_t;

	typedef enum logic [1:0] {
		STX_W16 = 2'h0,
		STX_W18 = 2'h1,
		STX_W20 = 2'h2,
		STX_W24 = 2'h3
	} stx_width_t;

	// ----------------------------------------------------------------
	// word lengths and bit-clock delays from frame sync edge to msb
	// ----------------------------------------------------------------
	localparam logic [5:0] STX_BITS_16   = 6'h10;
	localparam logic [5:0] STX_BITS_18   = 6'h12;
	localparam logic [5:0] STX_BITS_20   = 6'h14;
	localparam logic [5:0] STX_BITS_24   = 6'h18;
	localparam logic [5:0] STX_RJ_DLY_16 = 6'h10;
	localparam logic [5:0] STX_RJ_DLY_18 = 6'h0E;
	localparam logic [5:0] STX_RJ_DLY_20 = 6'h0C;
	localparam logic [5:0] STX_RJ_DLY_24 = 6'h08;
	localparam logic [5:0] STX_I2S_DLY   = 6'h01;
	localparam logic [5:0] STX_LJ_DLY    = 6'h00;
	localparam logic [5:0] STX_POS_MAX   = 6'h3F;
	localparam int         STX_SAMPLE_W  = 24;

	// ----------------------------------------------------------------
	// oversampling ratios and biphase cells per frame
	// ----------------------------------------------------------------
	localparam logic [9:0] STX_OSR_256       = 10'h100;
	localparam logic [9:0] STX_OSR_384       = 10'h180;
	localparam logic [9:0] STX_BIPHASE_FRAME = 10'h080;

endpackage

`default_nettype wire

/* stx_biphase_div.sv */
/*
 * divides oversampling clock edges down to the biphase cell rate.
 * assumes edge_tick is a one-cycle pulse per oversampling clock rise,
 * already synchronised to clock.
 */
`timescale 1ns/1ns
`default_nettype none

module stx_biphase_div (
	// system
	input  wire logic       clock,
	input  wire logic       sys_rst,
	// control
	input  wire logic [1:0] divisor,
	input  wire logic       edge_tick,
	// biphase timing
	output var  logic       biphase_tick,
	output var  logic       biphase_clk
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] cnt;
		logic       tick;
		logic       lvl;
	} stx_div_t;

	stx_div_t div_reg;
	stx_div_t div_next;

	always_comb begin
		div_next      = div_reg;
		div_next.tick = 1'b0;
		if (edge_tick) begin
			if (div_reg.cnt >= divisor - 2'h1) begin
				div_next.cnt  = 2'h0;
				div_next.tick = 1'b1;
				div_next.lvl  = ~div_reg.lvl;
			end else begin
				div_next.cnt = div_reg.cnt + 2'h1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_next;
		end
	end

	assign biphase_tick = div_reg.tick;
	assign biphase_clk  = div_reg.lvl;

endmodule

`default_nettype wire

/* stx_serial_in_assertions.sv */
/* port checks for stx_serial_in.
   assumes the bind below reaches every instance. */
`timescale 1ns/1ns
`default_nettype none
module stx_serial_in_sva (
	// system
	input wire logic        clock,
	input wire logic        sys_rst,
	// inputs
	input wire logic [1:0]  width_sel,
	input wire logic        bit_clk_pin,
	input wire logic        oversampling_clock_in,
	// outputs
	input wire logic [23:0] left_sample,
	input wire logic [23:0] right_sample,
	input wire logic        sample_valid,
	input wire logic        biphase_tick,
	input wire logic        biphase_clk
);
	// ----
	// checks
	// ----
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	tick_gap_a: assert property (biphase_tick |=> (!biphase_tick)[*6])
		else $error("biphase ticks too close");
	clk_follow_a: assert property ($changed(biphase_clk) == biphase_tick)
		else $error("biphase clock not tied to tick");
	tick_cause_a: assert property ((!oversampling_clock_in)[*8] |-> !biphase_tick)
		else $error("tick without oversampling edge");
	valid_cause_a: assert property ((!bit_clk_pin)[*8] |-> !sample_valid)
		else $error("word done without bit clock rise");
	valid_pulse_a: assert property (sample_valid |=> !sample_valid)
		else $error("sample valid longer than one cycle");
	right_upd_a: assert property ($changed(right_sample) |-> sample_valid)
		else $error("right word changed silently");
	left_held_a: assert property (sample_valid |-> $stable(left_sample))
		else $error("left word moved at pair end");
	short_word_a: assert property (sample_valid && width_sel == 2'h0 |-> right_sample[7:0] == 8'h00)
		else $error("16 bit word has low bits set");
endmodule
bind stx_serial_in stx_serial_in_sva u_sva (.clock, .sys_rst, .width_sel, .bit_clk_pin,
	.oversampling_clock_in, .left_sample, .right_sample, .sample_valid, .biphase_tick,
	.biphase_clk);
`default_nettype wire

/* stx_audio_src.sv */
/* serial audio source model: bit clock, frame sync, data, oversampling clock.
   assumes its tasks are called from one process at a time. */
`timescale 1ns/1ns
`default_nettype none
module stx_audio_src (
	// system
	input  wire logic clock,
	// serial lines
	output var  logic bclk,
	output var  logic fsync,
	output var  logic sdata,
	output var  logic osc
);
	// ----
	// lines
	// ----
	initial begin
		bclk = 1'b0;
		fsync = 1'b0;
		sdata = 1'b0;
		osc = 1'b0;
	end
	// change on the falling bit clock edge, far from capture
	task automatic bitp(input logic f, input logic d);
		@(posedge clock);
		bclk <= 1'b0;
		fsync <= f;
		sdata <= d;
		repeat (3) @(posedge clock);
		bclk <= 1'b1;
		repeat (4) @(posedge clock);
	endtask
	// 64 bit clocks a frame, two lead bits at the right level
	task automatic frame(input logic [1:0] fmt, input logic [1:0] w, input logic [23:0] l,
		input logic [23:0] r);
		int n;
		int d;
		logic lf;
		logic [23:0] wd;
		n = (w == 2'h3) ? 24 : 16 + 2 * w;
		d = (fmt == 2'h2) ? 32 - n : (fmt == 2'h1) ? 0 : 1;
		lf = (fmt == 2'h1 || fmt == 2'h2);
		bitp(!lf, 1'b1);
		bitp(!lf, 1'b0);
		for (int c = 0; c < 64; c++) begin
			wd = (c < 32) ? l : r;
			bitp(lf ^ (c >= 32), (c % 32 >= d && c % 32 < d + n) ?
				wd[23 - (c % 32 - d)] : c[0]);
		end
	endtask
	// one sixth of the clock rate, three cycles high and three low, so each edge is seen
	task automatic osc_edges(input int k);
		repeat (k) begin
			@(posedge clock);
			osc <= 1'b1;
			repeat (3) @(posedge clock);
			osc <= 1'b0;
			repeat (2) @(posedge clock);
		end
	endtask
endmodule
`default_nettype wire

/* stx_serial_in_test.sv */
/* self-checking bench for stx_serial_in.
   assumes stx_audio_src drives all serial pins. */
`timescale 1ns/1ns
`default_nettype none
module stx_serial_in_test;
	logic        clock;
	logic        sys_rst;
	logic [1:0]  format_sel;
	logic [1:0]  width_sel;
	logic        ratio_384;
	wire logic   bclk, fsync, sdata, osc;
	logic [23:0] left_sample, right_sample, cap_l, cap_r;
	logic        sample_valid, biphase_tick, biphase_clk;
	int          n_errors, tests_run, n_valid, n_tick;
	stx_audio_src u_src (.clock(clock), .bclk(bclk), .fsync(fsync), .sdata(sdata), .osc(osc));
	stx_serial_in u_dut (.clock(clock), .sys_rst(sys_rst), .format_sel(format_sel),
		.width_sel(width_sel), .ratio_384(ratio_384), .bit_clk_pin(bclk),
		.frame_sync_pin(fsync), .data_pin(sdata), .oversampling_clock_in(osc),
		.left_sample(left_sample), .right_sample(right_sample), .sample_valid(sample_valid),
		.biphase_tick(biphase_tick), .biphase_clk(biphase_clk));
	// ----
	// scenarios
	// ----
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		if (sample_valid === 1'b1) begin
			n_valid++;
			cap_l = left_sample;
			cap_r = right_sample;
		end
		if (biphase_tick === 1'b1) n_tick++;
	end
	task automatic check(input logic [51:0] seen, input logic [51:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic conclude;
		if (n_errors == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic do_reset(input logic [1:0] f, input logic [1:0] w, input logic q);
		@(posedge clock);
		sys_rst <= 1'b1;
		format_sel <= f;
		width_sel <= w;
		ratio_384 <= q;
		repeat (16) @(posedge clock);
		sys_rst <= 1'b0;
		@(negedge clock);
		check({left_sample, right_sample, sample_valid, biphase_tick, biphase_clk}, '0);
		n_valid = 0;
		n_tick = 0;
	endtask
	task automatic run_fmt(input logic [1:0] f, input logic [1:0] w);
		logic [23:0] m;
		m = 24'hFF_FFFF << ((w == 2'h3) ? 0 : 8 - 2 * w);
		do_reset(f, w, 1'b0);
		u_src.frame(f, w, 24'h5A_3C69, 24'hA5_C396);
		u_src.frame(f, w, 24'hA5_C396, 24'h5A_3C69);
		for (int i = 0; i < 40 && n_valid < 2; i++) @(posedge clock);
		if (n_valid < 2) begin
			n_errors++;
			conclude();
		end else begin
			check(52'(n_valid), 52'h2);
			check(52'(cap_l), 52'(24'hA5_C396 & m));
			check(52'(cap_r), 52'(24'h5A_3C69 & m));
		end
	endtask
	task automatic run_osc(input logic q);
		do_reset(2'h0, 2'h0, q);
		u_src.osc_edges(10);
		repeat (8) @(posedge clock);
		check(52'(n_tick), q ? 52'h3 : 52'h5);
		check(52'(biphase_clk), 52'h1);
	endtask
	initial begin
		sys_rst = 1'b1;
		format_sel = 2'h0;
		width_sel = 2'h0;
		ratio_384 = 1'b0;
		n_errors = 0;
		tests_run = 0;
		for (int f = 0; f < 4; f++) begin
			for (int w = 0; w < 4; w++) run_fmt(f[1:0], w[1:0]);
		end
		run_osc(1'b0);
		run_osc(1'b1);
		conclude();
	end
endmodule
`default_nettype wire
